// ==== hdl/brtc_top.sv ====
// battery-backed byte memory with a bcd clock in its top eight locations.
// assumes bus pins are synchronous to i_core_clk and i_osc_tick is one-cycle wide.
`timescale 1ns/10ps
module brtc_top #(
  parameter int KICK_TICKS = brtc_pkg::KICK_SECONDS * brtc_pkg::OSC_HZ,
  parameter int SEC_TICKS  = brtc_pkg::OSC_HZ
) (
  // clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  // memory bus
  input  wire logic [brtc_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic                         i_chip_en_n,
  input  wire logic                         i_out_en_n,
  input  wire logic                         i_write_en_n,
  input  wire logic [brtc_pkg::DATA_W-1:0]  i_data,
  output logic      [brtc_pkg::DATA_W-1:0]  o_data,
  output logic                              o_data_oe,
  output logic                              o_data_valid,
  // supply, battery and oscillator
  input  wire logic                         i_supply_ok,
  input  wire logic                         i_battery_low,
  input  wire logic                         i_osc_tick,
  output logic                              o_battery_low_flag,
  output logic                              o_osc_running
);
  typedef enum logic [1:0] {BRTC_IDLE, BRTC_READ, BRTC_WRITE} brtc_mode_t;

  logic [7:0]  mem_reg [brtc_pkg::MEM_DEPTH];
  logic [7:0]  hold_reg [8];
  logic [7:0]  c_sec_reg, c_min_reg, c_hour_reg, c_wday_reg;
  logic [7:0]  c_date_reg, c_month_reg, c_year_reg;
  brtc_mode_t  mode_next;
  logic [10:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic        wr_act_reg;
  logic [5:0]  acc_cnt_reg;
  logic [2:0]  hold_cnt_reg;
  logic [7:0]  rd_next;
  logic        wr_end;
  logic        is_clk_addr;
  logic [2:0]  clk_idx;
  logic [16:0] pre_cnt_reg;
  logic [16:0] sec_limit;
  logic [5:0]  cal_min_reg;
  logic        sec_pulse;
  logic        copy_reg;
  logic        osc_run_reg;
  logic [17:0] kick_cnt_reg;
  logic        bat_seen_reg;
  logic        load_counters;
  logic [4:0]  cal_mag;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // leap when the bcd year is a multiple of four
  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == brtc_pkg::MONTH_FEB) begin
      month_len = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      month_len = 8'h30;
    end else begin
      month_len = 8'h31;
    end
  endfunction

  // mode of the bus this cycle
  always_comb begin
    if (!i_supply_ok || i_chip_en_n) begin
      mode_next = BRTC_IDLE;
    end else if (!i_write_en_n) begin
      mode_next = BRTC_WRITE;
    end else begin
      mode_next = BRTC_READ;
    end
  end

  assign is_clk_addr = (i_addr >= brtc_pkg::OFS_CONTROL);
  assign clk_idx     = i_addr[2:0];
  assign cal_mag     = hold_reg[brtc_pkg::IDX_CONTROL][4:0];

  // read data mux, with the 512 Hz test tap on the seconds lsb
  always_comb begin
    rd_next = mem_reg[i_addr];
    if (is_clk_addr) begin
      rd_next = hold_reg[clk_idx];
      if (clk_idx == brtc_pkg::IDX_SECONDS &&
          hold_reg[brtc_pkg::IDX_WEEKDAY][brtc_pkg::BIT_FCHECK]) begin
        rd_next[0] = pre_cnt_reg[brtc_pkg::BIT_FT_TAP];
      end
    end
  end

  // write window: data sampled while active, committed at the end
  assign wr_end = wr_act_reg && (mode_next != BRTC_WRITE);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_act_reg <= 1'b0;
      wdata_reg  <= 8'h00;
    end else begin
      wr_act_reg <= (mode_next == BRTC_WRITE);
      if (mode_next == BRTC_WRITE) begin
        wdata_reg <= i_data;
      end
    end
  end

  // address tracking for access and hold timing
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg     <= 11'h000;
      acc_cnt_reg  <= 6'h00;
      hold_cnt_reg <= 3'h0;
    end else begin
      if (mode_next == BRTC_WRITE && wr_act_reg) begin
        addr_reg <= addr_reg;
      end else begin
        addr_reg <= i_addr;
      end
      if (mode_next != BRTC_READ || i_addr != addr_reg) begin
        acc_cnt_reg  <= 6'h00;
        hold_cnt_reg <= (mode_next == BRTC_READ) ? 3'h1 : 3'h0;
      end else begin
        if (acc_cnt_reg < 6'(brtc_pkg::ACCESS_CYC)) begin
          acc_cnt_reg <= acc_cnt_reg + 6'h01;
        end
        if (hold_cnt_reg < 3'(brtc_pkg::HOLD_CYC)) begin
          hold_cnt_reg <= hold_cnt_reg + 3'h1;
        end
      end
    end
  end

  // data pins: drive only in a read with outputs enabled
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data       <= 8'h00;
      o_data_oe    <= 1'b0;
      o_data_valid <= 1'b0;
    end else begin
      o_data_oe <= (mode_next == BRTC_READ) && !i_out_en_n;
      if (mode_next == BRTC_READ && i_addr == addr_reg &&
          acc_cnt_reg >= 6'(brtc_pkg::ACCESS_CYC - 1)) begin
        o_data       <= rd_next;
        o_data_valid <= 1'b1;
      end else if (mode_next == BRTC_READ && o_data_valid &&
                   (i_addr != addr_reg || hold_cnt_reg < 3'(brtc_pkg::HOLD_CYC))) begin
        o_data       <= o_data;
        o_data_valid <= 1'b1;
      end else begin
        o_data       <= 8'h00;
        o_data_valid <= 1'b0;
      end
    end
  end

  // battery check caught after reset release, cleared by the first write
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bat_seen_reg       <= 1'b0;
      o_battery_low_flag <= 1'b0;
    end else begin
      bat_seen_reg <= 1'b1;
      if (!bat_seen_reg) begin
        o_battery_low_flag <= i_battery_low;
      end else if (wr_end) begin
        o_battery_low_flag <= 1'b0;
      end
    end
  end

  // plain storage below the clock registers
  always_ff @(posedge i_core_clk) begin
    if (wr_end && !o_battery_low_flag && addr_reg < brtc_pkg::OFS_CONTROL) begin
      mem_reg[addr_reg] <= wdata_reg;
    end
  end

  // oscillator stop and kick-start restart
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_run_reg   <= 1'b1;
      kick_cnt_reg  <= 18'h00000;
      o_osc_running <= 1'b1;
    end else begin
      o_osc_running <= osc_run_reg;
      if (hold_reg[brtc_pkg::IDX_SECONDS][brtc_pkg::BIT_STOP]) begin
        osc_run_reg  <= 1'b0;
        kick_cnt_reg <= 18'h00000;
      end else if (!osc_run_reg && hold_reg[brtc_pkg::IDX_HOURS][brtc_pkg::BIT_BOOST] &&
                   i_osc_tick) begin
        if (kick_cnt_reg >= 18'(KICK_TICKS - 1)) begin
          osc_run_reg <= 1'b1;
        end else begin
          kick_cnt_reg <= kick_cnt_reg + 18'h00001;
        end
      end
    end
  end

  // second prescaler with calibration trim of the first 2n minutes
  always_comb begin
    sec_limit = 17'(SEC_TICKS - 1);
    if (c_sec_reg == brtc_pkg::BCD_ZERO && cal_mag != 5'h00 &&
        cal_min_reg < {cal_mag, 1'b0}) begin
      if (hold_reg[brtc_pkg::IDX_CONTROL][brtc_pkg::BIT_SIGN]) begin
        sec_limit = 17'(SEC_TICKS - 1 - brtc_pkg::TRIM_TICKS);
      end else begin
        sec_limit = 17'(SEC_TICKS - 1 + brtc_pkg::TRIM_TICKS);
      end
    end
  end

  assign sec_pulse = osc_run_reg && i_osc_tick && (pre_cnt_reg >= sec_limit);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_reg <= 17'h00000;
      cal_min_reg <= 6'h00;
      copy_reg    <= 1'b0;
    end else begin
      // copy one edge after the tick so the copies show the new count
      copy_reg <= sec_pulse;
      if (osc_run_reg && i_osc_tick) begin
        pre_cnt_reg <= sec_pulse ? 17'h00000 : pre_cnt_reg + 17'h00001;
      end
      if (sec_pulse && c_sec_reg == brtc_pkg::MAX_SEC) begin
        cal_min_reg <= (cal_min_reg == 6'(brtc_pkg::CAL_CYCLE - 1)) ? 6'h00
                                                                   : cal_min_reg + 6'h01;
      end
    end
  end

  // clearing the write bit loads counters from the copies
  assign load_counters = wr_end && !o_battery_low_flag &&
                         addr_reg == brtc_pkg::OFS_CONTROL &&
                         hold_reg[brtc_pkg::IDX_CONTROL][brtc_pkg::BIT_WRITE] &&
                         !wdata_reg[brtc_pkg::BIT_WRITE];

  // the real bcd counters
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      c_sec_reg   <= brtc_pkg::BCD_ZERO;
      c_min_reg   <= brtc_pkg::BCD_ZERO;
      c_hour_reg  <= brtc_pkg::BCD_ZERO;
      c_wday_reg  <= brtc_pkg::MIN_ONE;
      c_date_reg  <= brtc_pkg::MIN_ONE;
      c_month_reg <= brtc_pkg::MIN_ONE;
      c_year_reg  <= brtc_pkg::BCD_ZERO;
    end else if (load_counters) begin
      c_sec_reg   <= hold_reg[brtc_pkg::IDX_SECONDS] & brtc_pkg::MASK_SECONDS;
      c_min_reg   <= hold_reg[brtc_pkg::IDX_MINUTES] & brtc_pkg::MASK_MINUTES;
      c_hour_reg  <= hold_reg[brtc_pkg::IDX_HOURS] & brtc_pkg::MASK_HOURS;
      c_wday_reg  <= hold_reg[brtc_pkg::IDX_WEEKDAY] & brtc_pkg::MASK_WEEKDAY;
      c_date_reg  <= hold_reg[brtc_pkg::IDX_DATE] & brtc_pkg::MASK_DATE;
      c_month_reg <= hold_reg[brtc_pkg::IDX_MONTH] & brtc_pkg::MASK_MONTH;
      c_year_reg  <= hold_reg[brtc_pkg::IDX_YEAR];
    end else if (sec_pulse) begin
      c_sec_reg <= (c_sec_reg == brtc_pkg::MAX_SEC) ? brtc_pkg::BCD_ZERO : bcd_inc(c_sec_reg);
      if (c_sec_reg == brtc_pkg::MAX_SEC) begin
        c_min_reg <= (c_min_reg == brtc_pkg::MAX_SEC) ? brtc_pkg::BCD_ZERO
                                                      : bcd_inc(c_min_reg);
        if (c_min_reg == brtc_pkg::MAX_SEC) begin
          c_hour_reg <= (c_hour_reg == brtc_pkg::MAX_HOUR) ? brtc_pkg::BCD_ZERO
                                                           : bcd_inc(c_hour_reg);
          if (c_hour_reg == brtc_pkg::MAX_HOUR) begin
            c_wday_reg <= (c_wday_reg == brtc_pkg::MAX_WEEKDAY) ? brtc_pkg::MIN_ONE
                                                                : bcd_inc(c_wday_reg);
            if (c_date_reg >= month_len(c_month_reg, c_year_reg)) begin
              c_date_reg <= brtc_pkg::MIN_ONE;
              if (c_month_reg == brtc_pkg::MAX_MONTH) begin
                c_month_reg <= brtc_pkg::MIN_ONE;
                c_year_reg  <= (c_year_reg == brtc_pkg::MAX_YEAR) ? brtc_pkg::BCD_ZERO
                                                                  : bcd_inc(c_year_reg);
              end else begin
                c_month_reg <= bcd_inc(c_month_reg);
              end
            end else begin
              c_date_reg <= bcd_inc(c_date_reg);
            end
          end
        end
      end
    end
  end

  // visible copies: once-a-second transfer; a same-edge bus write overrides its own byte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        hold_reg[i] <= 8'h00;
      end
      hold_reg[brtc_pkg::IDX_WEEKDAY] <= brtc_pkg::MIN_ONE;
      hold_reg[brtc_pkg::IDX_DATE]    <= brtc_pkg::MIN_ONE;
      hold_reg[brtc_pkg::IDX_MONTH]   <= brtc_pkg::MIN_ONE;
    end else begin
      if (copy_reg &&
          !hold_reg[brtc_pkg::IDX_CONTROL][brtc_pkg::BIT_HALT] &&
          !hold_reg[brtc_pkg::IDX_CONTROL][brtc_pkg::BIT_WRITE]) begin
        // all fields in one cycle; special bits keep their stored value
        hold_reg[brtc_pkg::IDX_SECONDS] <= {hold_reg[brtc_pkg::IDX_SECONDS][7],
                                            c_sec_reg[6:0]};
        hold_reg[brtc_pkg::IDX_MINUTES] <= c_min_reg;
        hold_reg[brtc_pkg::IDX_HOURS]   <= {hold_reg[brtc_pkg::IDX_HOURS][7:6], c_hour_reg[5:0]};
        hold_reg[brtc_pkg::IDX_WEEKDAY] <= {hold_reg[brtc_pkg::IDX_WEEKDAY][7:3],
                                            c_wday_reg[2:0]};
        hold_reg[brtc_pkg::IDX_DATE]    <= c_date_reg;
        hold_reg[brtc_pkg::IDX_MONTH]   <= c_month_reg;
        hold_reg[brtc_pkg::IDX_YEAR]    <= c_year_reg;
      end
      if (wr_end && !o_battery_low_flag && addr_reg >= brtc_pkg::OFS_CONTROL) begin
        hold_reg[addr_reg[2:0]] <= wdata_reg;
      end
    end
  end
endmodule

// ==== shared/brtc_pkg.sv ====
// constants, offsets and field layout of the battery-backed memory with clock.
// assumes one core clock at 250 MHz and an oscillator tick pulse of 32768 Hz.
// How it works
// - chip enable low with write enable high means a read
// - address may ripple under chip enable; each new location is presented
// - data lines driven only while chip and output enable both low in a read
// - before the access delay ends the driven data is undefined
// - on address change old data holds briefly, then undefined until access ends
// - write spans both enables low, from later fall to earlier rise
// - output enable ignored in a write; low write enable turns outputs off
// - supply out of range deselects: inputs ignored, writes blocked, lines off
// - clock registers sit at 7f8 to 7ff, control lowest then seconds up to year
// - fields are packed bcd, 24-hour, with their documented ranges
// - date wraps at 28, 29 in leap years, 30 or 31 days
// - visible clock registers are copies loaded from counters once a second
// - plain memory access is never disturbed by the copy
// - read-halt bit 6 of control freezes the copies; counters keep running
// - copies update together, halt never cuts a copy, resume within a second
// - write bit 7 halts copies; clearing it loads counters from the copies
// - stop at seconds bit 7, kick at hour bit 7, test at day bit 6, control w r s
// - counters run from a 32768 Hz oscillator
// - five low control bits and sign trim one second per minute by 128 ticks
// - with test bit set the seconds lsb toggles at 512 Hz
// - stop bit halts the oscillator; restart needs kick-start for about two seconds
// - a low battery at power-up blocks the first write and clears the flag
package brtc_pkg;
  localparam int          ADDR_W       = 11;
  localparam int          DATA_W       = 8;
  localparam int          MEM_DEPTH    = 2048;
  localparam logic [10:0] OFS_CONTROL  = 11'h7f8;
  localparam logic [10:0] OFS_SECONDS  = 11'h7f9;
  localparam logic [10:0] OFS_MINUTES  = 11'h7fa;
  localparam logic [10:0] OFS_HOURS    = 11'h7fb;
  localparam logic [10:0] OFS_WEEKDAY  = 11'h7fc;
  localparam logic [10:0] OFS_DATE     = 11'h7fd;
  localparam logic [10:0] OFS_MONTH    = 11'h7fe;
  localparam logic [10:0] OFS_YEAR     = 11'h7ff;
  localparam logic [2:0]  IDX_CONTROL  = 3'h0;
  localparam logic [2:0]  IDX_SECONDS  = 3'h1;
  localparam logic [2:0]  IDX_MINUTES  = 3'h2;
  localparam logic [2:0]  IDX_HOURS    = 3'h3;
  localparam logic [2:0]  IDX_WEEKDAY  = 3'h4;
  localparam logic [2:0]  IDX_DATE     = 3'h5;
  localparam logic [2:0]  IDX_MONTH    = 3'h6;
  localparam logic [2:0]  IDX_YEAR     = 3'h7;
  localparam int          BIT_WRITE    = 7;
  localparam int          BIT_HALT     = 6;
  localparam int          BIT_SIGN     = 5;
  localparam int          BIT_STOP     = 7;
  localparam int          BIT_BOOST    = 7;
  localparam int          BIT_FCHECK   = 6;
  localparam int          BIT_FT_TAP   = 5;
  localparam logic [7:0]  MASK_SECONDS = 8'h7f;
  localparam logic [7:0]  MASK_MINUTES = 8'h7f;
  localparam logic [7:0]  MASK_HOURS   = 8'h3f;
  localparam logic [7:0]  MASK_WEEKDAY = 8'h07;
  localparam logic [7:0]  MASK_DATE    = 8'h3f;
  localparam logic [7:0]  MASK_MONTH   = 8'h1f;
  localparam logic [7:0]  MAX_SEC      = 8'h59;
  localparam logic [7:0]  MAX_HOUR     = 8'h23;
  localparam logic [7:0]  MAX_WEEKDAY  = 8'h07;
  localparam logic [7:0]  MAX_MONTH    = 8'h12;
  localparam logic [7:0]  MAX_YEAR     = 8'h99;
  localparam logic [7:0]  MIN_ONE      = 8'h01;
  localparam logic [7:0]  BCD_ZERO     = 8'h00;
  localparam logic [7:0]  MONTH_FEB    = 8'h02;
  localparam int          CLK_MHZ      = 250;
  localparam int          ACCESS_NS    = 120;
  localparam int          HOLD_NS      = 15;
  localparam int          ACCESS_CYC   = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int          HOLD_CYC     = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int          OSC_HZ       = 32768;
  localparam int          TRIM_TICKS   = 128;
  localparam int          CAL_CYCLE    = 64;
  localparam int          KICK_SECONDS = 2;
endpackage

// ==== verification/brtc_monitor.sv ====
// checker for bus pins and battery flag of the memory with clock.
// assumes it is bound to brtc_top and sees only its ports.
`timescale 1ns/10ps
module brtc_monitor (
  // clock and reset
  input wire logic                        i_core_clk,
  input wire logic                        i_rst,
  // bus
  input wire logic [brtc_pkg::ADDR_W-1:0] i_addr,
  input wire logic                        i_chip_en_n,
  input wire logic                        i_out_en_n,
  input wire logic                        i_write_en_n,
  input wire logic [brtc_pkg::DATA_W-1:0] o_data,
  input wire logic                        o_data_oe,
  input wire logic                        o_data_valid,
  // supply and battery
  input wire logic                        i_supply_ok,
  input wire logic                        o_battery_low_flag
);
  logic                        rd;
  logic                        wr;
  logic                        rd_q;
  logic [brtc_pkg::ADDR_W-1:0] addr_q;
  logic [7:0]                  acc_cnt;
  assign rd = i_supply_ok && !i_chip_en_n && i_write_en_n;
  assign wr = i_supply_ok && !i_chip_en_n && !i_write_en_n;
  // edges since the current read location was first seen
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_q    <= 1'b0;
      addr_q  <= '0;
      acc_cnt <= 8'h00;
    end else begin
      rd_q   <= rd;
      addr_q <= i_addr;
      if (!rd) acc_cnt <= 8'h00;
      else if (!rd_q || i_addr != addr_q) acc_cnt <= 8'h01;
      else if (acc_cnt != 8'hff) acc_cnt <= acc_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_read_oe;
    rd && !i_out_en_n;
  endsequence
  sequence s_flag_write_end;
    o_battery_low_flag && $past(wr) && !wr;
  endsequence
  sequence s_addr_hop;
    rd && rd_q && i_addr != addr_q && o_data_valid;
  endsequence
  AST_OE_ON: assert property (s_read_oe [*3] |-> o_data_oe)
    else $error("data pins not driven during read");
  AST_OE_HIGH_OFF: assert property (i_out_en_n [*2] |-> !o_data_oe)
    else $error("data pins driven with output enable high");
  AST_WRITE_OFF: assert property (!i_write_en_n [*2] |-> !o_data_oe)
    else $error("data pins driven with write enable low");
  AST_DESELECT_OFF: assert property ((i_chip_en_n || !i_supply_ok) [*2] |-> !o_data_oe)
    else $error("data pins driven while deselected");
  AST_ACCESS_DELAY: assert property ($rose(o_data_valid) |-> acc_cnt inside {[30:31]})
    else $error("valid data at wrong access time");
  AST_ADDR_HOP: assert property (s_addr_hop |=> ($stable(o_data) && o_data_valid) [*3] ##[1:4] !o_data_valid)
    else $error("old data not held then dropped after address change");
  AST_UNDEF_ZERO: assert property (!o_data_valid |-> o_data == 8'h00)
    else $error("undefined data not shown as zero");
  AST_BATT_CLEAR: assert property (s_flag_write_end |-> ##[1:2] !o_battery_low_flag)
    else $error("battery flag not cleared by first write");
endmodule
bind brtc_top brtc_monitor i_mon (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_chip_en_n(i_chip_en_n),
  .i_out_en_n(i_out_en_n), .i_write_en_n(i_write_en_n), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_data_valid(o_data_valid), .i_supply_ok(i_supply_ok),
  .o_battery_low_flag(o_battery_low_flag)
);

// ==== verification/brtc_bus_master.sv ====
// bus master model: asynchronous memory cycles launched on falling edges.
// assumes the device flags read data with a registered valid signal.
`timescale 1ns/10ps
module brtc_bus_master (
  // clock
  input  wire logic        i_core_clk,
  // answer from the device
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_dq_drive,
  input  wire logic        i_dq_valid,
  // bus pins
  output logic      [10:0] o_addr,
  output logic             o_chip_en_n,
  output logic             o_out_en_n,
  output logic             o_write_en_n,
  output logic      [7:0]  o_data
);
  // deselected from time zero so power-up makes no write
  initial begin
    o_addr       = 11'h000;
    o_chip_en_n  = 1'b1;
    o_out_en_n   = 1'b1;
    o_write_en_n = 1'b1;
    o_data       = 8'h00;
  end
  // two-wire control: output enable left low through the write
  task automatic bus_write(input logic [10:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_addr       = a;
    o_data       = d;
    o_out_en_n   = 1'b0;
    o_chip_en_n  = 1'b0;
    o_write_en_n = 1'b0;
    repeat (2) @(negedge i_core_clk);
    o_chip_en_n  = 1'b1;
    o_write_en_n = 1'b1;
    o_data       = ~d;
    repeat (3) @(negedge i_core_clk); // address kept, recovery gap
  endtask
  // read: wait for valid past the hold window, take data at that edge
  task automatic bus_read(input logic [10:0] a, input logic oe_n, input logic keep,
                          output logic [7:0] d, output logic drive, output int n);
    @(negedge i_core_clk);
    o_addr       = a;
    o_out_en_n   = oe_n;
    o_write_en_n = 1'b1;
    o_chip_en_n  = 1'b0;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (n < 80 && !(n > 5 && i_dq_valid === 1'b1));
    d     = i_dq;
    drive = i_dq_drive;
    if (!keep) begin
      @(negedge i_core_clk);
      o_chip_en_n = 1'b1;
      repeat (3) @(negedge i_core_clk);
    end
  endtask
endmodule

// ==== verification/brtc_top_tb.sv ====
// self-checking bench for brtc_top, one task per scenario.
// assumes the bus master model and the checker file are compiled first.
`timescale 1ns/10ps
module brtc_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        supply_ok = 1'b1;
  logic        bat_low = 1'b0;
  logic        tick = 1'b0;
  logic [1:0]  tick_cnt = 2'h0;
  logic [10:0] addr;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [7:0]  m_data;
  logic [7:0]  rdata;
  logic [7:0]  dq;
  logic        drive;
  logic        valid;
  logic        bat_flag;
  logic        osc_run;
  int          n_mismatch = 0;
  int          comparisons = 0;
  assign dq = drive ? rdata : m_data;
  always #2 clk = ~clk;
  // oscillator tick every fourth core cycle
  always @(negedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    tick     <= tick_cnt == 2'h3;
  end
  brtc_top #(.KICK_TICKS(8), .SEC_TICKS(300)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_chip_en_n(ce_n),
    .i_out_en_n(oe_n), .i_write_en_n(we_n), .i_data(dq), .o_data(rdata),
    .o_data_oe(drive), .o_data_valid(valid), .i_supply_ok(supply_ok),
    .i_battery_low(bat_low), .i_osc_tick(tick), .o_battery_low_flag(bat_flag),
    .o_osc_running(osc_run)
  );
  brtc_bus_master i_master (
    .i_core_clk(clk), .i_dq(dq), .i_dq_drive(drive), .i_dq_valid(valid), .o_addr(addr),
    .o_chip_en_n(ce_n), .o_out_en_n(oe_n), .o_write_en_n(we_n), .o_data(m_data)
  );
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_ok(input int n);
    if (n >= 80) begin
      $display("Error read valid expected 1 seen 0");
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] q);
    logic d;
    int   n;
    i_master.bus_read(a, 1'b0, 1'b0, q, d, n);
    wait_ok(n);
  endtask
  task automatic do_reset(input logic b);
    bat_low = b;
    rst     = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_mem;
    logic [10:0] a [3] = '{11'h000, 11'h3a5, 11'h7f7};
    logic [7:0]  d [3] = '{8'h5a, 8'hc3, 8'h0f};
    logic [7:0]  q;
    logic        o;
    int          n;
    for (int i = 0; i < 3; i++) i_master.bus_write(a[i], d[i]);
    for (int i = 0; i < 3; i++) begin
      rd(a[i], q);
      check("stored byte", d[i], q);
    end
    i_master.bus_read(a[1], 1'b1, 1'b0, q, o, n);
    wait_ok(n);
    check("drive with output enable high", 8'h00, {7'h00, o});
    i_master.bus_read(a[0], 1'b0, 1'b1, q, o, n);
    wait_ok(n);
    check("drive in read", 8'h01, {7'h00, o});
    i_master.bus_read(a[2], 1'b0, 1'b0, q, o, n);
    check("ripple byte", d[2], q);
    check("access delay", 8'h01, {7'h00, (n inside {[30:31]})});
    $display("test mem done");
  endtask
  task automatic t_supply;
    logic [7:0] q;
    @(negedge clk) supply_ok = 1'b0;
    i_master.bus_write(11'h3a5, 8'h99);
    supply_ok = 1'b1;
    rd(11'h3a5, q);
    check("write while supply low", 8'hc3, q);
    $display("test supply done");
  endtask
  task automatic t_battery;
    logic [7:0] q;
    do_reset(1'b1);
    check("battery flag", 8'h01, {7'h00, bat_flag});
    i_master.bus_write(11'h000, 8'h11);
    check("flag after write", 8'h00, {7'h00, bat_flag});
    rd(11'h000, q);
    check("blocked write", 8'h5a, q);
    i_master.bus_write(11'h000, 8'h22);
    rd(11'h000, q);
    check("second write", 8'h22, q);
    $display("test battery done");
  endtask
  task automatic t_clock;
    logic [7:0] yr [2] = '{8'h01, 8'h04};
    logic [7:0] dt [2] = '{8'h01, 8'h29};
    logic [7:0] mo [2] = '{8'h03, 8'h02};
    logic [7:0] v [7];
    logic [7:0] e [8];
    logic [7:0] q;
    logic [7:0] s1;
    for (int i = 0; i < 2; i++) begin
      v = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, yr[i]};
      e = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h01, dt[i], mo[i], yr[i]};
      i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h80);
      for (int j = 0; j < 7; j++) i_master.bus_write(brtc_pkg::OFS_SECONDS + 11'(j), v[j]);
      i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h00);
      repeat (1500) @(negedge clk);
      i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h40);
      for (int j = 0; j < 8; j++) begin
        rd(brtc_pkg::OFS_CONTROL + 11'(j), q);
        if (j != 1) check("clock register", e[j], q);
      end
      rd(brtc_pkg::OFS_SECONDS, s1);
      check("seconds wrap", 8'h01, {7'h00, (s1 inside {8'h00, 8'h01})});
      repeat (1300) @(negedge clk);
      rd(brtc_pkg::OFS_SECONDS, q);
      check("held seconds", s1, q);
      i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h00);
      repeat (1300) @(negedge clk);
      i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h40);
      rd(brtc_pkg::OFS_SECONDS, q);
      check("seconds resumed", 8'h01, {7'h00, (q !== s1)});
    end
    $display("test clock done");
  endtask
  task automatic t_osc;
    i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h80);
    i_master.bus_write(brtc_pkg::OFS_SECONDS, 8'h80);
    check("oscillator stopped", 8'h00, {7'h00, osc_run});
    i_master.bus_write(brtc_pkg::OFS_SECONDS, 8'h00);
    check("restart without kick", 8'h00, {7'h00, osc_run});
    i_master.bus_write(brtc_pkg::OFS_HOURS, 8'h80);
    repeat (40) @(negedge clk);
    check("kicked oscillator", 8'h01, {7'h00, osc_run});
    i_master.bus_write(brtc_pkg::OFS_HOURS, 8'h00);
    i_master.bus_write(brtc_pkg::OFS_CONTROL, 8'h00);
    $display("test osc done");
  endtask
  initial begin
    do_reset(1'b0);
    t_mem();
    t_supply();
    t_battery();
    t_clock();
    t_osc();
    finish_test();
  end
endmodule
